/* File: gyro_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by the gyro offset and rate filter block; the package does not include it
// Notes: Rates are in hertz; cycle counts derive from the clock rate
`ifndef GYRO_CFG_SVH
`define GYRO_CFG_SVH

`define ADDR_Z_OFFSET_HIGH 8'h17
`define ADDR_Z_OFFSET_LOW 8'h18
`define ADDR_SAMPLE_DIV 8'h19
`define ADDR_FILTER_CFG 8'h1a
`define ADDR_GYRO_CFG 8'h1b

`define CFG_RSVD_BIT 7
`define CFG_FIFO_MODE_BIT 6
`define CFG_SYNC_HI 5
`define CFG_SYNC_LO 3
`define CFG_LP_HI 2
`define CFG_LP_LO 0
`define GCFG_FS_HI 4
`define GCFG_FS_LO 3
`define GCFG_BYP_HI 1
`define GCFG_BYP_LO 0
`define GCFG_MASK 8'h1b

`define REG_RESET 8'h00

// Offset step in micro-dps per LSB, at the +-1000 dps range
`define OFFSET_STEP_UDPS 30500

`define CLK_HZ 125000000
`define RATE_32K_HZ 32000
`define RATE_8K_HZ 8000
`define RATE_1K_HZ 1000
`define TICK_32K_CYC (`CLK_HZ / `RATE_32K_HZ)
`define TICK_8K_CYC (`CLK_HZ / `RATE_8K_HZ)
`define TICK_1K_CYC (`CLK_HZ / `RATE_1K_HZ)

`define CH_TEMP 0
`define CH_GYRO_X 1
`define CH_GYRO_Z 3
`define NUM_CH 7

`endif

/* File: gyro_pkg.sv */
// Purpose: Types shared by the gyro offset and rate filter block
// Assumes: Sixteen-bit signed sensor words
// Notes: Channel order is temp, gyro x/y/z, accel x/y/z
package gyro_pkg;
	typedef logic signed [15:0] word_t;
	typedef logic [6:0][15:0] channels_t;
	typedef enum logic [1:0] {RATE_32K, RATE_8K, RATE_1K} rate_e;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;
endpackage

/* File: gyro_offset_rate_filter.sv */
// Purpose: Z gyro offset, sample-rate divider, filter, sync and FIFO policy
// Assumes: Register port decoded from the serial host link upstream
// Notes: Raw samples arrive on this clock; the sync pin does not
//
// Summary of operation
// RL1: Z offset is 16-bit two's complement, high byte then low byte.
// RL2: Offset is added to each filtered Z gyro sample before output register.
// RL3: One offset step equals 0.0305 dps of correction.
// RL4: Output rate is 1 kHz divided by one plus the divider.
// RL5: Divided rate drives both output register updates and FIFO writes.
// RL6: Divider applies only with bypass bits zero and setting 1 to 6.
// RL7: FIFO mode 1 drops writes when full; 0 overwrites the oldest.
// RL8: Sync select routes latched sync pin into bit 0 of chosen low byte.
// RL9: Sync latch toggles on one edge per strobe, rearmed by the sample strobe.
// RL10: Lowpass setting takes effect only when both bypass bits are zero.
// RL11: Internal rate 32 kHz when bypassed, 8 kHz for 0 or 7, else 1 kHz.
// RL12: Gyro bandwidth follows the bypass and lowpass setting table.
// RL13: Bypass bits sit in bits 1..0 of the gyro configuration register.
// RL14: Host writes zero to configuration bit 7.
`include "gyro_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module gyro_offset_rate_filter
#(
	parameter int FIFO_DEPTH = 16,
	parameter int TICK_8K = `TICK_8K_CYC,
	parameter int TICK_1K = `TICK_1K_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire gyro_pkg::reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	// Sensor front end
	input wire gyro_pkg::channels_t raw_in,
	input wire logic frame_sync_pin,
	// Sensor output registers
	output gyro_pkg::channels_t sensor_out,
	output logic sample_strobe,
	output logic [13:0] gyro_bandwidth_hz,
	output gyro_pkg::rate_e internal_rate,
	// FIFO drain
	input wire logic fifo_pop,
	output logic [15:0] fifo_data,
	output logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level
);
	import gyro_pkg::*;

	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	logic [7:0] z_gyro_offset_high;
	logic [7:0] z_gyro_offset_low;
	logic [7:0] sample_rate_divider;
	logic [6:0] filter_sync_fifo_config;
	logic [4:0] gyro_config;
	logic [1:0] filter_bypass_bits;
	logic [1:0] full_scale;
	logic [2:0] lowpass_setting;
	logic [2:0] sync_target_select;
	logic fifo_drop_mode;
	word_t z_gyro_offset_value;
	rate_e next_rate;
	logic [16:0] tick_cnt;
	logic [16:0] tick_period;
	logic rate_tick;
	logic [7:0] div_cnt;
	logic div_active;
	logic next_strobe;
	logic sync_meta;
	logic sync_s;
	logic sync_prev;
	logic sync_latched;
	logic sync_locked;
	word_t filt [3];
	channels_t next_out;
	logic [15:0] fifo_mem [FIFO_DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic fifo_full;
	logic do_pop;

	assign filter_bypass_bits = gyro_config[`GCFG_BYP_HI:`GCFG_BYP_LO];
	assign full_scale = gyro_config[`GCFG_FS_HI:`GCFG_FS_LO];
	assign lowpass_setting = filter_sync_fifo_config[`CFG_LP_HI:`CFG_LP_LO];
	assign sync_target_select =
		filter_sync_fifo_config[`CFG_SYNC_HI:`CFG_SYNC_LO];
	assign fifo_drop_mode = filter_sync_fifo_config[`CFG_FIFO_MODE_BIT];
	// RL1: offset byte pairing
	assign z_gyro_offset_value = {z_gyro_offset_high, z_gyro_offset_low};

	// RL11: internal rate choice
	function automatic rate_e rate_of(input logic [1:0] byp,
		input logic [2:0] lp);
		if (byp != 2'h0)
			return RATE_32K;
		else if (lp == 3'h0 || lp == 3'h7)
			return RATE_8K;
		else
			return RATE_1K;
	endfunction

	// RL12: bandwidth table
	function automatic logic [13:0] bw_of(input logic [1:0] byp,
		input logic [2:0] lp);
		if (byp[0])
			return 14'd8173;
		else if (byp[1])
			return 14'd3281;
		unique case (lp)
			3'h0: return 14'd250;
			3'h1: return 14'd176;
			3'h2: return 14'd92;
			3'h3: return 14'd41;
			3'h4: return 14'd20;
			3'h5: return 14'd10;
			3'h6: return 14'd5;
			3'h7: return 14'd3281;
		endcase
	endfunction

	// Smoothing depth: narrower bandwidth, longer time constant
	function automatic logic [2:0] shift_of(input logic [1:0] byp,
		input logic [2:0] lp);
		if (byp != 2'h0)
			return 3'h0;
		else if (lp == 3'h7)
			return 3'h1;
		else
			return lp + 3'h1;
	endfunction

	// Register writes; reserved bit 7 and gyro config bits 7..5 are not stored
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			z_gyro_offset_high <= `REG_RESET;
			z_gyro_offset_low <= `REG_RESET;
			sample_rate_divider <= `REG_RESET;
			filter_sync_fifo_config <= 7'h00;
			gyro_config <= 5'h00;
		end
		else if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				`ADDR_Z_OFFSET_HIGH: z_gyro_offset_high <= reg_req.wdata;
				`ADDR_Z_OFFSET_LOW: z_gyro_offset_low <= reg_req.wdata;
				`ADDR_SAMPLE_DIV: sample_rate_divider <= reg_req.wdata;
				// RL14: bit 7 is dropped
				`ADDR_FILTER_CFG: filter_sync_fifo_config <= reg_req.wdata[6:0];
				// RL13: bypass bits kept here
				`ADDR_GYRO_CFG: gyro_config <= reg_req.wdata[4:0];
				default: ;
			endcase
		end
	end

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
		begin
			unique case (reg_req.addr)
				`ADDR_Z_OFFSET_HIGH: reg_rdata <= z_gyro_offset_high;
				`ADDR_Z_OFFSET_LOW: reg_rdata <= z_gyro_offset_low;
				`ADDR_SAMPLE_DIV: reg_rdata <= sample_rate_divider;
				`ADDR_FILTER_CFG: reg_rdata <= {1'b0, filter_sync_fifo_config};
				`ADDR_GYRO_CFG: reg_rdata <= {3'h0, gyro_config} & `GCFG_MASK;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// RL10: filter config gating
	assign next_rate = rate_of(filter_bypass_bits, lowpass_setting);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			internal_rate <= RATE_8K;
			gyro_bandwidth_hz <= 14'd250;
		end
		else
		begin
			internal_rate <= next_rate;
			// RL12: bandwidth report
			gyro_bandwidth_hz <= bw_of(filter_bypass_bits, lowpass_setting);
		end
	end

	// RL11: internal tick period
	always_comb
	begin
		unique case (internal_rate)
			RATE_32K: tick_period = 17'(`TICK_32K_CYC);
			RATE_8K: tick_period = 17'(TICK_8K);
			RATE_1K: tick_period = 17'(TICK_1K);
			default: tick_period = 17'(TICK_1K);
		endcase
	end

	// A shortened period restarts the count instead of running past it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tick_cnt <= 17'h0;
		else if (tick_cnt >= tick_period - 17'h1)
			tick_cnt <= 17'h0;
		else
			tick_cnt <= tick_cnt + 17'h1;
	end
	assign rate_tick = (tick_cnt >= tick_period - 17'h1);

	// RL6: divider qualification
	assign div_active = (filter_bypass_bits == 2'h0) &&
		(lowpass_setting != 3'h0) && (lowpass_setting != 3'h7);

	// RL4: divide by one plus divider
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			div_cnt <= 8'h00;
		else if (rate_tick)
		begin
			if (!div_active || div_cnt >= sample_rate_divider)
				div_cnt <= 8'h00;
			else
				div_cnt <= div_cnt + 8'h01;
		end
	end
	assign next_strobe = rate_tick &&
		(!div_active || div_cnt >= sample_rate_divider);

	// Sync pin synchroniser
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync_meta <= 1'b0;
			sync_s <= 1'b0;
			sync_prev <= 1'b0;
		end
		else
		begin
			sync_meta <= frame_sync_pin;
			sync_s <= sync_meta;
			sync_prev <= sync_s;
		end
	end

	// RL9: one toggle per strobe
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync_latched <= 1'b0;
			sync_locked <= 1'b0;
		end
		else if (next_strobe)
			sync_locked <= 1'b0;
		else if ((sync_s ^ sync_prev) && !sync_locked)
		begin
			sync_latched <= ~sync_latched;
			sync_locked <= 1'b1;
		end
	end

	// RL10: gyro lowpass per axis
	for (genvar g = 0; g < 3; g++)
	begin : gyro_lp
		logic signed [16:0] diff;
		assign diff = 17'(signed'(raw_in[`CH_GYRO_X + g])) - 17'(filt[g]);
		always_ff @(posedge clk)
		begin
			if (!rst_n)
				filt[g] <= 16'sh0000;
			else if (rate_tick)
				filt[g] <= 16'(17'(filt[g]) +
					(diff >>> shift_of(filter_bypass_bits, lowpass_setting)));
		end
	end

	// Output assembly with offset, saturation and sync bit
	always_comb
	begin
		logic signed [17:0] off_scaled;
		logic signed [17:0] sum;
		off_scaled = 18'(z_gyro_offset_value);
		sum = 18'sd0;
		// RL3: step scaled to range
		unique case (full_scale)
			2'h0: off_scaled = off_scaled <<< 1;
			2'h1: off_scaled = off_scaled;
			2'h2: off_scaled = off_scaled >>> 1;
			2'h3: off_scaled = off_scaled >>> 2;
		endcase
		next_out = raw_in;
		for (int c = 0; c < 3; c++)
			next_out[`CH_GYRO_X + c] = filt[c];
		// RL2: offset added
		sum = 18'(signed'(next_out[`CH_GYRO_Z])) + off_scaled;
		if (sum > 18'sd32767)
			next_out[`CH_GYRO_Z] = 16'h7fff;
		else if (sum < -18'sd32768)
			next_out[`CH_GYRO_Z] = 16'h8000;
		else
			next_out[`CH_GYRO_Z] = sum[15:0];
		// RL8: sync bit routing
		for (int c = 0; c < `NUM_CH; c++)
			if (sync_target_select != 3'h0 && c == sync_target_select - 3'h1)
				next_out[c][0] = sync_latched;
	end

	// RL5: output register update
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sensor_out <= '0;
			sample_strobe <= 1'b0;
		end
		else
		begin
			sample_strobe <= next_strobe;
			if (next_strobe)
				sensor_out <= next_out;
		end
	end

	// Z gyro FIFO; pop is ignored when empty
	assign fifo_full = (fifo_level == LW'(FIFO_DEPTH));
	assign do_pop = fifo_pop && fifo_level != '0;

	// RL7: overflow policy
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fifo_level <= '0;
			fifo_data <= 16'h0000;
		end
		else
		begin
			if (do_pop)
				fifo_data <= fifo_mem[rd_ptr];
			// RL5: FIFO write rate
			if (next_strobe && !(fifo_full && fifo_drop_mode))
			begin
				fifo_mem[wr_ptr] <= next_out[`CH_GYRO_Z];
				wr_ptr <= PW'((32'(wr_ptr) + 1) % FIFO_DEPTH);
				if (fifo_full || do_pop)
					rd_ptr <= PW'((32'(rd_ptr) + 1) % FIFO_DEPTH);
				if (!fifo_full && !do_pop)
					fifo_level <= fifo_level + LW'(1);
			end
			else if (do_pop)
			begin
				rd_ptr <= PW'((32'(rd_ptr) + 1) % FIFO_DEPTH);
				fifo_level <= fifo_level - LW'(1);
			end
		end
	end
endmodule

`default_nettype wire

/* File: gyro_offset_rate_filter_assertions.sv */
// Purpose: Port checks for the offset, rate and filter block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the block below
`timescale 1ns/100ps
`default_nettype none
module gyro_offset_rate_filter_assertions
#(
	parameter int FIFO_DEPTH = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire gyro_pkg::reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire gyro_pkg::channels_t sensor_out,
	input wire logic sample_strobe,
	input wire logic [13:0] gyro_bandwidth_hz,
	input wire gyro_pkg::rate_e internal_rate,
	input wire logic fifo_pop,
	input wire logic [15:0] fifo_data,
	input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level
);
	import gyro_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Bandwidths that only the 1 kHz settings give
	wire logic bw_1k = gyro_bandwidth_hz inside
		{14'h0b0, 14'h05c, 14'h029, 14'h014, 14'h00a, 14'h005};

	a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
		else $error("strobe longer than one cycle");
	a_out_hold: assert property (!sample_strobe |-> $stable(sensor_out))
		else $error("output changed without strobe");
	a_level_bound: assert property (fifo_level <= FIFO_DEPTH)
		else $error("fifo level above depth");
	a_pop_empty: assert property (fifo_pop && fifo_level == 0
		|=> $stable(fifo_data)) else $error("pop taken from empty fifo");
	a_bw_rate: assert property (bw_1k && $stable(gyro_bandwidth_hz)
		|-> internal_rate == RATE_1K) else $error("rate not 1 kHz");
	a_unmapped_zero: assert property (!(reg_req.addr inside
		{[8'h17:8'h1b]}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cfg_bit7: assert property (reg_req.addr == 8'h1a
		|=> !reg_rdata[7]) else $error("config bit 7 reads one");
	a_offset_rdback: assert property ((reg_req.wr &&
		reg_req.addr == 8'h17) ##1 (!reg_req.wr && reg_req.addr == 8'h17)
		|=> reg_rdata == $past(reg_req.wdata, 2))
		else $error("offset high byte lost");

	c_strobe: cover property (sample_strobe);
	c_pop: cover property (fifo_pop && fifo_level != 0);
	c_full: cover property (sample_strobe && fifo_level == FIFO_DEPTH);
endmodule

bind gyro_offset_rate_filter gyro_offset_rate_filter_assertions
	#(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk(clk), .rst_n(rst_n),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .sensor_out(sensor_out),
	.sample_strobe(sample_strobe), .gyro_bandwidth_hz(gyro_bandwidth_hz),
	.internal_rate(internal_rate), .fifo_pop(fifo_pop),
	.fifo_data(fifo_data), .fifo_level(fifo_level));
`default_nettype wire

/* File: gyro_host_model.sv */
// Purpose: Host side of the register port
// Assumes: Requests launched on a rising edge
// Notes: Address is held after a write, so reads may follow at once
`timescale 1ns/100ps
`default_nettype none
module gyro_host_model
(
	// Register port
	input wire logic clk,
	output var gyro_pkg::reg_req_s req,
	input wire logic [7:0] rdata
);
	import gyro_pkg::*;
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, a, d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	// Read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		@(posedge clk);
		#1;
		d = rdata;
	endtask
endmodule
`default_nettype wire

/* File: tb_gyro_offset_rate_filter.sv */
// Purpose: Self-checking bench for the offset, rate and filter block
// Assumes: Short tick parameters, sixteen-word fifo
// Notes: Bypass uses the fixed 32 kHz period, so it runs last
`timescale 1ns/100ps
`default_nettype none
module tb_gyro_offset_rate_filter;
	import gyro_pkg::*;
	localparam int TK8 = 40;
	localparam int TK1 = 60;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	reg_req_s reg_req;
	logic [7:0] reg_rdata;
	channels_t raw_in = {48'h0, 16'h0064, 48'h0};
	logic frame_sync_pin = 1'b0;
	channels_t sensor_out;
	logic sample_strobe;
	logic [13:0] gyro_bandwidth_hz;
	rate_e internal_rate;
	logic fifo_pop = 1'b0;
	logic [15:0] fifo_data;
	logic [4:0] fifo_level;
	int fails = 0;
	int num_checks = 0;
	logic [7:0] rd;
	int n;
	always #4 clk = ~clk;
	gyro_offset_rate_filter #(.TICK_8K(TK8), .TICK_1K(TK1)) dut (
		.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.raw_in(raw_in), .frame_sync_pin(frame_sync_pin),
		.sensor_out(sensor_out), .sample_strobe(sample_strobe),
		.gyro_bandwidth_hz(gyro_bandwidth_hz), .internal_rate(internal_rate),
		.fifo_pop(fifo_pop), .fifo_data(fifo_data), .fifo_level(fifo_level));
	gyro_host_model host (.clk(clk), .req(reg_req), .rdata(reg_rdata));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait for the next strobe; returns the cycles waited
	task automatic wstb(output int c);
		c = 0;
		do
		begin
			@(posedge clk);
			#1;
			c++;
		end
		while (sample_strobe !== 1'b1 && c < 5000);
	endtask
	task automatic t_regs;
		logic [7:0] a[5] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h30};
		logic [7:0] e[5] = '{8'hab, 8'hcd, 8'h05, 8'h7f, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			host.wr(a[i], i == 3 ? 8'hff : e[i]);
			host.rd(a[i], rd);
			chk({8'h00, rd}, {8'h00, e[i]});
		end
		$display("t_regs done");
	endtask
	task automatic t_rate;
		host.wr(8'h1b, 8'h08);
		host.wr(8'h19, 8'h02);
		host.wr(8'h1a, 8'h01);
		repeat (3) wstb(n);
		chk(16'(n), 16'(TK1 * 3));
		chk({2'b00, gyro_bandwidth_hz}, 16'h00b0);
		chk({14'h0, internal_rate}, {14'h0, RATE_1K});
		host.wr(8'h1a, 8'h00);
		repeat (3) wstb(n);
		chk(16'(n), 16'(TK8));
		chk({2'b00, gyro_bandwidth_hz}, 16'h00fa);
		$display("t_rate done");
	endtask
	task automatic t_sync;
		host.wr(8'h1a, 8'h20);
		repeat (2) wstb(n);
		chk({15'h0, sensor_out[3][0]}, 16'h0000);
		@(posedge clk);
		frame_sync_pin <= 1'b1;
		repeat (2) @(posedge clk);
		frame_sync_pin <= 1'b0;
		repeat (2) wstb(n);
		chk({15'h0, sensor_out[3][0]}, 16'h0001);
		$display("t_sync done");
	endtask
	task automatic t_fifo;
		host.wr(8'h1a, 8'h40);
		wstb(n);
		@(posedge clk);
		fifo_pop <= 1'b1;
		repeat (24) @(posedge clk);
		fifo_pop <= 1'b0;
		#1;
		chk(16'(fifo_level), 16'h0000);
		repeat (17) wstb(n);
		chk(16'(fifo_level), 16'h0010);
		@(posedge clk);
		fifo_pop <= 1'b1;
		@(posedge clk);
		fifo_pop <= 1'b0;
		#1;
		// Settled Z filter 0x0063 plus offset 0xabcd from the register test
		chk(fifo_data, 16'hac30);
		$display("t_fifo done");
	endtask
	task automatic t_offset;
		host.wr(8'h17, 8'hff);
		host.wr(8'h18, 8'hf0);
		host.wr(8'h1a, 8'h00);
		host.wr(8'h1b, 8'h0a);
		repeat (2) wstb(n);
		chk(sensor_out[3], 16'h0054);
		chk({2'b00, gyro_bandwidth_hz}, 16'h0cd1);
		chk({14'h0, internal_rate}, {14'h0, RATE_32K});
		$display("t_offset done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_rate();
		t_sync();
		t_fifo();
		t_offset();
		summarize();
	end
	// Tests need about 9400 cycles; the 25000-cycle limit means a hang
	initial
	begin
		#200000;
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
